// ===== bench/async_serial_transceiver_test.sv
/* self-checking bench; assumes serial_peer on the line and rate selects at zero */
`timescale 1ns/1ps
module async_serial_transceiver_test;
    import serial_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    ctrl_t ctrl = '0;
    logic status_access = 1'b0;
    logic data_write = 1'b0;
    logic data_read = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic rx_line, tx_serial_out, tx_pin_oe, rx_ninth_bit, irq_req;
    status_t status;
    logic [7:0] rx_data;
    logic [8:0] rnd = 9'h00c;
    logic [8:0] a, b;
    int error_cnt = 0;
    int total_checks = 0;
    always #25 clock = ~clock;
    async_serial_transceiver i_dut (.clock(clock), .resetn(resetn), .ctrl(ctrl), .status_access(status_access),
        .data_write(data_write), .wr_data(wr_data), .data_read(data_read), .rx_serial_in(rx_line),
        .tx_serial_out(tx_serial_out), .tx_pin_oe(tx_pin_oe), .status(status), .rx_data(rx_data),
        .rx_ninth_bit(rx_ninth_bit), .irq_req(irq_req));
    // released pin floats to the pull-up level
    serial_peer i_peer (.clock(clock), .tx_line(tx_pin_oe ? tx_serial_out : 1'b1), .nine(ctrl.nine_bit_select),
        .rx_line(rx_line));
    function automatic logic [8:0] lfsr(input logic [8:0] s);
        return {s[7:0], s[8] ^ s[4]};
    endfunction
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // status access, then one data read or write
    task automatic access(input logic wr, input logic [7:0] d);
        @(negedge clock) status_access = 1'b1;
        @(negedge clock) status_access = 1'b0;
        data_write = wr;
        data_read = !wr;
        wr_data = d;
        @(negedge clock) data_write = 1'b0;
        data_read = 1'b0;
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog well past the expected run length
    initial
    begin
        repeat (40000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end
    // main sequence, once per word length
    initial
    begin
        int c;
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        check("reset flags", {7'h00, status.tx_empty_flag, status.tx_done_flag}, 9'h003);
        for (int n = 0; n < 2; n++)
        begin
            ctrl.nine_bit_select = n[0];
            ctrl.global_irq_mask = n[0];
            ctrl.rx_enable = 1'b1;
            ctrl.rx_irq_en = 1'b1;
            repeat (220) @(negedge clock);
            check("idle", {8'h00, status.idle_flag}, 9'h001);
            access(1'b0, 8'h00);
            a = rnd;
            rnd = lfsr(rnd);
            b = rnd;
            rnd = lfsr(rnd);
            i_peer.send(a, 1'b1);
            repeat (8) @(negedge clock);
            check("rx word", {rx_ninth_bit, rx_data}, n[0] ? a : {1'b0, a[7:0]});
            check("rx irq", {7'h00, status.rx_full_flag, irq_req}, {7'h00, 1'b1, !n[0]});
            // second word lands on a full buffer
            i_peer.send(b, 1'b1);
            repeat (8) @(negedge clock);
            check("overrun", {status.overrun_flag, rx_data}, {1'b1, a[7:0]});
            access(1'b0, 8'h00);
            check("cleared", {7'h00, status.rx_full_flag, status.overrun_flag}, 9'h000);
            i_peer.send(b, 1'b0);
            repeat (8) @(negedge clock);
            check("framing", {7'h00, status.framing_err_flag, status.rx_full_flag}, 9'h003);
            access(1'b0, 8'h00);
            ctrl.rx_enable = 1'b0;
            ctrl.tx_ninth_bit = b[8];
            ctrl.tx_enable = 1'b1;
            access(1'b1, a[7:0]);
            c = 0;
            while (status.tx_empty_flag !== 1'b1 && c < 400)
            begin
                @(negedge clock);
                c++;
            end
            check("idle first", {8'h00, c >= 150 && c < 400}, 9'h001);
            access(1'b1, b[7:0]);
            check("tx empty", {8'h00, status.tx_empty_flag}, 9'h000);
            c = 0;
            while (i_peer.got.size() < 2 && c < 800)
            begin
                @(negedge clock);
                c++;
            end
            repeat (20) @(negedge clock);
            check("tx word a", i_peer.got.pop_front(), {b[8] & n[0], a[7:0]});
            check("tx word b", i_peer.got.pop_front(), {b[8] & n[0], b[7:0]});
            // write while idle goes straight to the line
            access(1'b1, ~b[7:0]);
            check("direct", {6'h00, tx_pin_oe, status.tx_empty_flag, status.tx_done_flag}, 9'h006);
            c = 0;
            while (i_peer.got.size() < 1 && c < 400)
            begin
                @(negedge clock);
                c++;
            end
            repeat (20) @(negedge clock);
            check("tx word c", i_peer.got.pop_front(), {b[8] & n[0], ~b[7:0]});
            check("tx done", {8'h00, status.tx_done_flag}, 9'h001);
            ctrl.send_break = 1'b1;
            repeat (40) @(negedge clock);
            ctrl.send_break = 1'b0;
            repeat (400) @(negedge clock);
            check("break", i_peer.got.pop_front(), 9'h000);
            ctrl.tx_enable = 1'b0;
            repeat (20) @(negedge clock);
            check("pin released", {8'h00, tx_pin_oe}, 9'h000);
        end
        wrap_up();
    end
endmodule

// ===== bench/serial_peer.sv
/* far-side serial device model; assumes the fastest rate, 16 clocks a bit */
`timescale 1ns/1ps
module serial_peer
(
    input wire logic clock,
    input wire logic tx_line,
    input wire logic nine,
    output logic rx_line
);
    logic [9:0] sh;
    logic [8:0] got[$];
    initial rx_line = 1'b1;
    task automatic send(input logic [8:0] w, input logic stop);
        logic [10:0] f;
        f = nine ? {stop, w, 1'b0} : {1'b1, stop, w[7:0], 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++)
        begin
            rx_line = f[i];
            repeat (16) @(negedge clock);
        end
        rx_line = 1'b1;
    endtask
    // mid-bit sampling; stops before the next start so back-to-back frames are seen
    always @(negedge tx_line)
    begin
        repeat (8) @(posedge clock);
        for (int i = 0; i < (nine ? 10 : 9); i++)
        begin
            repeat (16) @(posedge clock);
            sh[i] = tx_line;
        end
        got.push_back(nine ? sh[8:0] : {1'b0, sh[7:0]});
    end
endmodule

// ===== design/async_serial_transceiver.sv
/*
 * Full-duplex asynchronous serial transceiver with 16x oversampled receiver.
 * Assumes the cpu side drives one-cycle access strobes on clock; rx_serial_in
 * is asynchronous and is synchronised here.
 */
// Contract
// - enabled and nothing pending keeps transmit pin high; both disabled releases it.
// - frame is low start, 8 or 9 data bits lsb first, high stop.
// - nine-bit mode sends tx_ninth_bit as the ninth data bit.
// - nine-bit mode puts the received ninth bit into rx_ninth_bit.
// - enabling the transmitter sends one all-ones idle frame first.
// - re-enable during sending queues idle frame after word, drops buffered word.
// - status access then data write clears tx_empty_flag and tx_done_flag.
// - write while busy buffers; write while idle starts at once, empty set.
// - end of data or break frame sets tx_done_flag, interrupt if enabled.
// - tx_empty_flag requests interrupt when enabled and unmasked.
// - send_break repeats zero frames; after clearing, one high bit follows.
// - rx_enable starts the search for a start bit.
// - received character loads rx_buffer, sets rx_full_flag, interrupt if enabled.
// - status access then data read clears rx_full_flag.
// - character while full sets overrun_flag, keeps rx_buffer, interrupt if enabled.
// - noisy frame sets noise_flag with rx_full_flag, data kept, no own interrupt.
// - missing stop bit or break sets framing_err_flag with rx_full_flag.
// - idle frame handled like a character, plus interrupt if idle_irq_en.
// - each direction rate is clock over 16, prescaler and own divider.
// - prescaler 1,3,4,13; dividers powers of two from 1 to 128.
// - majority of samples 8, 9, 10 of 16; resync on each start.
`timescale 1ns/1ps
module async_serial_transceiver
(
    input wire logic clock,
    input wire logic resetn,
    input wire serial_pkg::ctrl_t ctrl,
    input wire logic status_access,
    input wire logic data_write,
    input wire logic [7:0] wr_data,
    input wire logic data_read,
    input wire logic rx_serial_in,
    output logic tx_serial_out,
    output logic tx_pin_oe,
    output serial_pkg::status_t status,
    output logic [7:0] rx_data,
    output logic rx_ninth_bit,
    output logic irq_req
);
    import serial_pkg::*;

    typedef enum logic [1:0] {TX_OFF, TX_IDLE, TX_SEND} tx_state_t;
    typedef enum logic [1:0] {K_IDLE, K_DATA, K_BREAK, K_MARK} tx_kind_t;
    typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_FRAME} rx_state_t;

    function automatic logic [10:0] data_frame(input logic nine, input logic [8:0] w);
        return nine ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
    endfunction

    // shared by both directions: status access arms the data access that follows
    logic arm_q, arm_d;

    // transmitter state
    tx_state_t tx_st_q, tx_st_d;
    tx_kind_t tx_kind_q, tx_kind_d;
    logic [10:0] tx_sh_q, tx_sh_d, tx_div_q, tx_div_d;
    logic [3:0] tx_bits_q, tx_bits_d, tx_os_q, tx_os_d;
    logic [8:0] tx_buf_q, tx_buf_d;
    logic tx_buf_full_q, tx_buf_full_d, idle_pend_q, idle_pend_d, ten_q, ten_d;
    logic tx_empty_q, tx_empty_d, tx_done_q, tx_done_d, tx_pin_q, tx_pin_d, tx_oe_q, tx_oe_d;
    logic tx_tick, tx_bit_end, tx_end;

    // receiver state
    rx_state_t rx_st_q, rx_st_d;
    logic rx_s1_q, rx_s2_q, rx_s3_q;
    logic [10:0] rx_div_q, rx_div_d, rx_sh_q, rx_sh_d, rx_sh_n;
    logic [3:0] rx_os_q, rx_os_d, rx_bit_q, rx_bit_d;
    logic [2:0] rx_vote_q, rx_vote_d;
    logic [7:0] idle_cnt_q, idle_cnt_d;
    logic [8:0] rx_buf_q, rx_buf_d, rx_word;
    logic rx_noise_q, rx_noise_d, idle_arm_q, idle_arm_d, rx_tick, rx_maj;
    logic rx_full_q, rx_full_d, idle_q, idle_d, ovr_q, ovr_d, nf_q, nf_d, fe_q, fe_d;
    logic rx_event, ev_idle, ev_noise, ev_frame;
    logic irq_q, irq_d;

    assign arm_d = status_access | (arm_q & ~data_write & ~data_read);

    // transmit tick and bit boundaries
    // tx rate
    assign tx_tick = (tx_div_q == 11'(tick_period(ctrl.baud_prescale_sel, ctrl.tx_rate_div_sel) - 11'h001));
    assign tx_bit_end = tx_tick && (tx_os_q == OS_LAST);
    assign tx_end = (tx_st_q == TX_SEND) && tx_bit_end && (tx_bits_q == MARK_LEN);

    // transmitter next state: frame choice, buffer and flags
    always_comb
    begin
        tx_st_d = tx_st_q;
        tx_kind_d = tx_kind_q;
        tx_sh_d = tx_sh_q;
        tx_bits_d = tx_bits_q;
        tx_os_d = tx_os_q;
        tx_div_d = 11'h000;
        tx_buf_d = tx_buf_q;
        tx_buf_full_d = tx_buf_full_q;
        idle_pend_d = idle_pend_q;
        ten_d = ctrl.tx_enable;
        tx_empty_d = tx_empty_q;
        tx_done_d = tx_done_q;
        // enable edge queues an idle frame and drops the buffer
        if (ctrl.tx_enable && !ten_q)
        begin
            idle_pend_d = 1'b1;
            tx_buf_full_d = 1'b0;
        end
        if (data_write)
        begin
            // clear only after a status access; a set below still wins
            if (arm_q)
            begin
                tx_empty_d = 1'b0;
                tx_done_d = 1'b0;
            end
            // direct start when idle, otherwise hold in the buffer
            if (tx_st_q == TX_IDLE && ctrl.tx_enable && !idle_pend_q && !ctrl.send_break && !tx_buf_full_q)
            begin
                tx_st_d = TX_SEND;
                tx_kind_d = K_DATA;
                tx_sh_d = data_frame(ctrl.nine_bit_select, {ctrl.tx_ninth_bit, wr_data});
                tx_bits_d = frame_len(ctrl.nine_bit_select);
                tx_os_d = 4'h0;
                tx_empty_d = 1'b1;
            end
            else
            begin
                tx_buf_d = {ctrl.tx_ninth_bit, wr_data};
                tx_buf_full_d = 1'b1;
            end
        end
        unique case (tx_st_q)
            TX_OFF:
            begin
                if (ctrl.tx_enable)
                begin
                    tx_st_d = TX_IDLE;
                end
            end
            TX_IDLE, TX_SEND:
            begin
                if (tx_st_q == TX_SEND && !tx_end)
                begin
                    tx_div_d = tx_tick ? 11'h000 : 11'(tx_div_q + 11'h001);
                    if (tx_tick)
                    begin
                        tx_os_d = 4'(tx_os_q + 4'h1);
                    end
                    // shift out lsb first, ones behind
                    if (tx_bit_end)
                    begin
                        tx_sh_d = {1'b1, tx_sh_q[10:1]};
                        tx_bits_d = 4'(tx_bits_q - 4'h1);
                    end
                end
                else
                begin
                    // completion of a data or break frame
                    if (tx_end && (tx_kind_q == K_DATA || tx_kind_q == K_BREAK))
                    begin
                        tx_done_d = 1'b1;
                    end
                    tx_os_d = 4'h0;
                    tx_bits_d = frame_len(ctrl.nine_bit_select);
                    tx_st_d = TX_SEND;
                    // one high bit after the last break frame
                    if (tx_end && tx_kind_q == K_BREAK && !ctrl.send_break)
                    begin
                        tx_kind_d = K_MARK;
                        tx_sh_d = FRAME_ONES;
                        tx_bits_d = MARK_LEN;
                    end
                    else if (!ctrl.tx_enable)
                    begin
                        tx_st_d = TX_OFF;
                    end
                    else if (idle_pend_q)
                    begin
                        tx_kind_d = K_IDLE;
                        tx_sh_d = FRAME_ONES;
                        idle_pend_d = 1'b0;
                    end
                    // break frame zero over the whole length
                    else if (ctrl.send_break)
                    begin
                        tx_kind_d = K_BREAK;
                        tx_sh_d = FRAME_ZEROS;
                    end
                    // buffer to shift register, buffer free again
                    else if (tx_buf_full_q)
                    begin
                        tx_kind_d = K_DATA;
                        tx_sh_d = data_frame(ctrl.nine_bit_select, tx_buf_q);
                        // a write in this same cycle refills the freed buffer, so keep it
                        tx_buf_full_d = data_write;
                        tx_empty_d = 1'b1;
                    end
                    else if (tx_st_q == TX_SEND)
                    begin
                        tx_st_d = TX_IDLE;
                    end
                    else if (!data_write)
                    begin
                        tx_st_d = TX_IDLE;
                    end
                end
            end
        endcase
        // pin high unless a frame bit is low; released only when both sides are off
        tx_pin_d = (tx_st_d == TX_SEND) ? tx_sh_d[0] : 1'b1;
        tx_oe_d = ctrl.tx_enable | ctrl.rx_enable | (tx_st_d == TX_SEND);
    end

    // transmitter registers
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            tx_st_q <= TX_OFF;
            tx_kind_q <= K_IDLE;
            tx_sh_q <= FRAME_ONES;
            tx_bits_q <= 4'h0;
            tx_os_q <= 4'h0;
            tx_div_q <= 11'h000;
            tx_buf_q <= 9'h000;
            tx_buf_full_q <= 1'b0;
            idle_pend_q <= 1'b0;
            ten_q <= 1'b0;
            tx_empty_q <= TX_EMPTY_RST;
            tx_done_q <= TX_DONE_RST;
            tx_pin_q <= 1'b1;
            tx_oe_q <= 1'b0;
            arm_q <= 1'b0;
        end
        else
        begin
            tx_st_q <= tx_st_d;
            tx_kind_q <= tx_kind_d;
            tx_sh_q <= tx_sh_d;
            tx_bits_q <= tx_bits_d;
            tx_os_q <= tx_os_d;
            tx_div_q <= tx_div_d;
            tx_buf_q <= tx_buf_d;
            tx_buf_full_q <= tx_buf_full_d;
            idle_pend_q <= idle_pend_d;
            ten_q <= ten_d;
            tx_empty_q <= tx_empty_d;
            tx_done_q <= tx_done_d;
            tx_pin_q <= tx_pin_d;
            tx_oe_q <= tx_oe_d;
            arm_q <= arm_d;
        end
    end

    // receive tick, majority vote and the frame as it would look after this bit
    // rx rate
    assign rx_tick = (rx_div_q == 11'(tick_period(ctrl.baud_prescale_sel, ctrl.rx_rate_div_sel) - 11'h001));
    assign rx_maj = (rx_vote_q[0] & rx_vote_q[1]) | (rx_vote_q[1] & rx_vote_q[2]) | (rx_vote_q[0] & rx_vote_q[2]);
    assign rx_sh_n = {rx_maj, rx_sh_q[10:1]};
    // ninth bit sits above the byte; 8-bit frames land one place higher
    assign rx_word = ctrl.nine_bit_select ? rx_sh_n[9:1] : {1'b0, rx_sh_n[9:2]};

    // receiver next state: hunt, sample, deliver
    always_comb
    begin
        rx_st_d = rx_st_q;
        rx_div_d = 11'h000;
        rx_os_d = rx_os_q;
        rx_bit_d = rx_bit_q;
        rx_vote_d = rx_vote_q;
        rx_sh_d = rx_sh_q;
        rx_noise_d = rx_noise_q;
        idle_cnt_d = 8'h00;
        idle_arm_d = idle_arm_q;
        rx_event = 1'b0;
        ev_idle = 1'b0;
        ev_noise = 1'b0;
        ev_frame = 1'b0;
        unique case (rx_st_q)
            RX_OFF:
            begin
                if (ctrl.rx_enable)
                begin
                    rx_st_d = RX_HUNT;
                    idle_arm_d = 1'b1;
                end
            end
            RX_HUNT:
            begin
                rx_div_d = rx_tick ? 11'h000 : 11'(rx_div_q + 11'h001);
                idle_cnt_d = rx_s2_q ? idle_cnt_q : 8'h00;
                // falling edge restarts the sample clock
                if (rx_s3_q && !rx_s2_q)
                begin
                    rx_st_d = RX_FRAME;
                    rx_div_d = 11'h000;
                    rx_os_d = 4'h0;
                    rx_bit_d = 4'h0;
                    rx_noise_d = 1'b0;
                end
                else if (rx_tick && rx_s2_q && idle_arm_q)
                begin
                    idle_cnt_d = 8'(idle_cnt_q + 8'h01);
                    // a whole frame of ones counts as an idle character
                    if (idle_cnt_q == 8'({frame_len(ctrl.nine_bit_select), 4'h0} - 8'h01))
                    begin
                        rx_event = 1'b1;
                        ev_idle = 1'b1;
                        idle_arm_d = 1'b0;
                        idle_cnt_d = 8'h00;
                    end
                end
            end
            RX_FRAME:
            begin
                rx_div_d = rx_tick ? 11'h000 : 11'(rx_div_q + 11'h001);
                if (rx_tick)
                begin
                    rx_os_d = 4'(rx_os_q + 4'h1);
                    if (rx_os_q == SAMPLE_FIRST)
                    begin
                        rx_vote_d[0] = rx_s2_q;
                    end
                    if (rx_os_q == SAMPLE_MID)
                    begin
                        rx_vote_d[1] = rx_s2_q;
                    end
                    if (rx_os_q == SAMPLE_LAST)
                    begin
                        rx_vote_d[2] = rx_s2_q;
                    end
                    if (rx_os_q == OS_LAST)
                    begin
                        rx_sh_d = rx_sh_n;
                        rx_bit_d = 4'(rx_bit_q + 4'h1);
                        // any disagreement among the three marks the frame
                        rx_noise_d = rx_noise_q | ~(&rx_vote_q) & (|rx_vote_q);
                        if (rx_bit_q == 4'h0 && rx_maj)
                        begin
                            rx_st_d = RX_HUNT;
                        end
                        else if (rx_bit_q == 4'(frame_len(ctrl.nine_bit_select) - 4'h1))
                        begin
                            rx_st_d = RX_HUNT;
                            idle_arm_d = 1'b1;
                            rx_event = 1'b1;
                            ev_noise = rx_noise_d;
                            ev_frame = ~rx_maj;
                        end
                    end
                end
            end
            default:
            begin
                rx_st_d = RX_OFF;
            end
        endcase
        if (!ctrl.rx_enable)
        begin
            rx_st_d = RX_OFF;
        end
    end

    // receive flags and buffer: clear by status then read, set wins
    always_comb
    begin
        rx_buf_d = rx_buf_q;
        rx_full_d = rx_full_q;
        idle_d = idle_q;
        ovr_d = ovr_q;
        nf_d = nf_q;
        fe_d = fe_q;
        if (data_read && arm_q)
        begin
            rx_full_d = 1'b0;
            idle_d = 1'b0;
            ovr_d = 1'b0;
            nf_d = 1'b0;
            fe_d = 1'b0;
        end
        if (rx_event)
        begin
            if (rx_full_q)
            begin
                ovr_d = 1'b1;
            end
            else
            begin
                rx_buf_d = ev_idle ? IDLE_WORD : rx_word;
                rx_full_d = 1'b1;
                idle_d = ev_idle;
                nf_d = ev_noise;
                fe_d = ev_frame;
            end
        end
        // interrupt request, one level for all sources
        irq_d = ~ctrl.global_irq_mask & ((tx_empty_d & ctrl.tx_empty_irq_en) | (tx_done_d & ctrl.tx_done_irq_en)
            | ((rx_full_d | ovr_d) & ctrl.rx_irq_en) | (idle_d & ctrl.idle_irq_en));
    end

    // receiver registers; line synchroniser first stage feeds only the second
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            rx_st_q <= RX_OFF;
            rx_div_q <= 11'h000;
            rx_os_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_vote_q <= 3'h0;
            rx_sh_q <= FRAME_ZEROS;
            rx_noise_q <= 1'b0;
            idle_cnt_q <= 8'h00;
            idle_arm_q <= 1'b0;
            rx_buf_q <= 9'h000;
            rx_full_q <= 1'b0;
            idle_q <= 1'b0;
            ovr_q <= 1'b0;
            nf_q <= 1'b0;
            fe_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            rx_s1_q <= rx_serial_in;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            rx_st_q <= rx_st_d;
            rx_div_q <= rx_div_d;
            rx_os_q <= rx_os_d;
            rx_bit_q <= rx_bit_d;
            rx_vote_q <= rx_vote_d;
            rx_sh_q <= rx_sh_d;
            rx_noise_q <= rx_noise_d;
            idle_cnt_q <= idle_cnt_d;
            idle_arm_q <= idle_arm_d;
            rx_buf_q <= rx_buf_d;
            rx_full_q <= rx_full_d;
            idle_q <= idle_d;
            ovr_q <= ovr_d;
            nf_q <= nf_d;
            fe_q <= fe_d;
            irq_q <= irq_d;
        end
    end

    // outputs are flop bits only
    assign tx_serial_out = tx_pin_q;
    assign tx_pin_oe = tx_oe_q;
    assign rx_data = rx_buf_q[7:0];
    assign rx_ninth_bit = rx_buf_q[8];
    assign irq_req = irq_q;
    assign status = '{tx_empty_flag: tx_empty_q, tx_done_flag: tx_done_q, rx_full_flag: rx_full_q,
        idle_flag: idle_q, overrun_flag: ovr_q, noise_flag: nf_q, framing_err_flag: fe_q};

    a_idle_pin_high: assert property (@(posedge clock) disable iff (!resetn) (tx_st_q == TX_IDLE) |-> tx_pin_q)
        else $error("transmit pin low while idle");
    a_pin_owned: assert property (@(posedge clock) disable iff (!resetn) (tx_st_q != TX_OFF) |-> tx_oe_q)
        else $error("pin released while transmitter active");
    a_direct_load: assert property (@(posedge clock) disable iff (!resetn)
        (data_write && tx_st_q == TX_IDLE && ctrl.tx_enable && !idle_pend_q && !ctrl.send_break && !tx_buf_full_q)
        |=> (tx_st_q == TX_SEND) && tx_empty_q && !tx_pin_q)
        else $error("idle write did not start a frame");
    a_done_set: assert property (@(posedge clock) disable iff (!resetn)
        (tx_end && tx_kind_q == K_DATA) |=> tx_done_q)
        else $error("tx_done_flag not set after frame");
    a_break_low: assert property (@(posedge clock) disable iff (!resetn)
        (tx_st_q == TX_SEND && tx_kind_q == K_BREAK) |-> !tx_pin_q)
        else $error("break frame drove a high bit");
    a_empty_hold: assert property (@(posedge clock) disable iff (!resetn)
        (tx_empty_q && data_write && !arm_q) |=> tx_empty_q)
        else $error("tx_empty_flag cleared without status access");
    a_rx_deliver: assert property (@(posedge clock) disable iff (!resetn)
        (rx_event && !rx_full_q && !ev_idle) |=> rx_full_q && (rx_buf_q == $past(rx_word)))
        else $error("received word not delivered");
    a_overrun_keep: assert property (@(posedge clock) disable iff (!resetn)
        (rx_event && rx_full_q) |=> ovr_q && $stable(rx_buf_q))
        else $error("overrun altered buffer or missed flag");
    a_irq_masked: assert property (@(posedge clock) disable iff (!resetn) ctrl.global_irq_mask |=> !irq_q)
        else $error("interrupt raised while masked");
endmodule

// ===== design/serial_pkg.sv
/*
 * Shared constants and types for the asynchronous serial transceiver.
 * Assumes a single synchronous clock domain; the line input is asynchronous.
 */
package serial_pkg;

    // oversampling and centre samples (0-based tick index inside a bit)
    localparam logic [3:0] OS_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_FIRST = 4'h7;
    localparam logic [3:0] SAMPLE_MID = 4'h8;
    localparam logic [3:0] SAMPLE_LAST = 4'h9;

    // frame lengths in bits: start + data + stop, and the lone mark bit
    localparam logic [3:0] FRAME8_LEN = 4'ha;
    localparam logic [3:0] FRAME9_LEN = 4'hb;
    localparam logic [3:0] MARK_LEN = 4'h1;

    // shared prescaler choices
    localparam logic [10:0] PRESCALE_0 = 11'h001;
    localparam logic [10:0] PRESCALE_1 = 11'h003;
    localparam logic [10:0] PRESCALE_2 = 11'h004;
    localparam logic [10:0] PRESCALE_3 = 11'h00d;

    // values after reset, and the word an idle frame loads
    localparam logic TX_EMPTY_RST = 1'b1;
    localparam logic TX_DONE_RST = 1'b1;
    localparam logic [10:0] FRAME_ONES = 11'h7ff;
    localparam logic [10:0] FRAME_ZEROS = 11'h000;
    localparam logic [8:0] IDLE_WORD = 9'h1ff;

    typedef struct packed {
        logic nine_bit_select;
        logic tx_ninth_bit;
        logic tx_enable;
        logic rx_enable;
        logic send_break;
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_irq_en;
        logic idle_irq_en;
        logic global_irq_mask;
        logic [1:0] baud_prescale_sel;
        logic [2:0] tx_rate_div_sel;
        logic [2:0] rx_rate_div_sel;
    } ctrl_t;

    typedef struct packed {
        logic tx_empty_flag;
        logic tx_done_flag;
        logic rx_full_flag;
        logic idle_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_err_flag;
    } status_t;

    // clock cycles per 16x tick: prescaler times power-of-two divider
    function automatic logic [10:0] tick_period(input logic [1:0] psel, input logic [2:0] dsel);
        logic [10:0] pr;
        pr = PRESCALE_0;
        case (psel)
            2'h1: pr = PRESCALE_1;
            2'h2: pr = PRESCALE_2;
            2'h3: pr = PRESCALE_3;
            default: pr = PRESCALE_0;
        endcase
        return 11'(pr << dsel);
    endfunction

    function automatic logic [3:0] frame_len(input logic nine);
        return nine ? FRAME9_LEN : FRAME8_LEN;
    endfunction

endpackage
